//--- logic/rtca_consts.svh
// Constants for the real-time clock access and alarm block.
// Assumes a 100 MHz system clock and a 32.768 kHz low-speed rate.
`ifndef RTCA_CONSTS_SVH
`define RTCA_CONSTS_SVH

// ****************************************************************
// Rates
// ****************************************************************
`define RTCA_CLK_HZ 100000000
`define RTCA_LS_HZ 32768
// Nearest whole divide; the low-speed rate is not an exact fraction.
`define RTCA_LS_DIV ((`RTCA_CLK_HZ + `RTCA_LS_HZ / 2) / `RTCA_LS_HZ)
`define RTCA_SEC_CNT_W 15
`define RTCA_SEC_CNT_MAX 15'h7FFF
`define RTCA_HZ16_MASK 15'h07FF

// ****************************************************************
// Time field limits and alarm defaults
// ****************************************************************
`define RTCA_SEC_MAX 6'h3B
`define RTCA_SEC_HALF 6'h1E
`define RTCA_MIN_MAX 6'h3B
`define RTCA_HOUR_MAX 5'h17
`define RTCA_DATE_MAX 5'h1F
`define RTCA_DATE_FIRST 5'h01
`define RTCA_DOW_MAX 3'h6
`define RTCA_DOW_SUNDAY 3'h0
`define RTCA_ZERO6 6'h00
`define RTCA_ZERO5 5'h00

`endif

//--- logic/rtca_pkg.sv
// Types shared by the real-time clock access and alarm block.
// Assumes rtca_consts.svh is included by the modules that use it.
package rtca_pkg;

    typedef struct packed {
        logic [4:0] date;
        logic [2:0] dow;
        logic [4:0] hour;
        logic [5:0] min;
        logic [5:0] sec;
    } rtca_time_t;

    typedef struct packed {
        logic [4:0] date;
        logic [2:0] dow;
        logic [4:0] hour;
        logic [5:0] min;
    } rtca_alarm_t;

    typedef struct packed {
        logic clock_run_enable;
        logic interrupt_enable;
        logic alarm_enable;
        logic bank_select;
        logic one_hz_disable;
        logic sixteen_hz_disable;
    } rtca_ctrl_t;

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_ALARM,
        SRC_1HZ,
        SRC_16HZ
    } rtca_src_t;

endpackage

//--- logic/rtca_prescaler.sv
// Low-speed enable divider and 15-bit second counter.
// Assumes one system clock; the clear request is held until taken.
`timescale 1ns/1ps
`include "rtca_consts.svh"

module rtca_prescaler
    import rtca_pkg::*;
#(
    parameter int LS_DIV = `RTCA_LS_DIV
) (
    input wire logic clk_in,      // System clock.
    input wire logic rst_n_in,    // Asynchronous reset, active low.
    input wire logic clr_in,      // Second counter clear request.
    output logic ls_tick_out,     // One pulse per low-speed period.
    output logic sec_tick_out,    // One pulse per second.
    output logic hz16_tick_out    // One pulse per sixteenth second.
);

    typedef struct packed {
        logic [11:0] div;
        logic [`RTCA_SEC_CNT_W-1:0] cnt;
    } rtca_pre_state_t;

    rtca_pre_state_t s_q;
    rtca_pre_state_t s_d;

    assign ls_tick_out = (s_q.div == 12'(LS_DIV - 1));
    assign sec_tick_out = ls_tick_out && !clr_in &&
        (s_q.cnt == `RTCA_SEC_CNT_MAX);
    assign hz16_tick_out = ls_tick_out && !clr_in &&
        ((s_q.cnt & `RTCA_HZ16_MASK) == `RTCA_HZ16_MASK);

    always_comb begin
        s_d = s_q;
        s_d.div = ls_tick_out ? 12'h000 : s_q.div + 12'h001;
        if (ls_tick_out) begin
            if (clr_in) begin
                s_d.cnt = 15'h0000;
            end else begin
                s_d.cnt = s_q.cnt + 15'h0001;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_clear_restarts: assert property (
        ls_tick_out && clr_in |=> s_q.cnt == 15'h0000)
        else $error("second counter not cleared by reset request");
    // The divider restarts from zero after each tick, so ticks never touch
    // as long as the divide is at least two.
    chk_tick_spacing: assert property (
        ls_tick_out |=> !ls_tick_out && s_q.div == 12'h000)
        else $error("low-speed ticks too close together");

endmodule

//--- logic/rtca_top.sv
// Real-time clock time keeping, safe access aids and alarm pin output.
// Assumes control levels and request pulses are synchronous to CLK_IN.
`timescale 1ns/1ps
`include "rtca_consts.svh"

// Contract
// - Divide low-speed rate to a 1 Hz tick that advances the time.
// - The 1 Hz interrupt fires on the same tick that counts seconds.
// - After counter reset, first 1 Hz interrupt comes one second later.
// - Clearing clock run enable halts time and carries; counter runs.
// - Bank select one maps alarm writes; pin has three sources.
// - Each event gives one low-speed-period pulse on pin and irq while interrupt enable is set.
// - The irq is active on its falling edge; controller detects that.
// - Time equal to alarm fields pulses the pin and raises irq.
// - Alarm clear sets minute 0, hour 0, date 1, Sunday.
// - Alarm logic samples on the low-speed tick, up to one period late.
// - Alarm off, 1 Hz on, 16 Hz off gives a 1 Hz pulse train.
// - Alarm off, 1 Hz off, 16 Hz on gives a 16 Hz pulse train.
// - Rounding applies at next second; 30 and up carries; busy till done.
// - Counter reset taken on low-speed tick; busy until done.
// - Source is alarm, 1 Hz, 16 Hz per disables, else none.
module rtca_top
    import rtca_pkg::*;
#(
    parameter int LS_DIV = `RTCA_LS_DIV
) (
    input wire logic CLK_IN,            // System clock, 100 MHz.
    input wire logic RST_N_IN,          // Asynchronous reset, active low.
    input wire rtca_ctrl_t CTRL_IN,     // Control and configuration levels.
    input wire logic TIME_WE_IN,        // Pulse: load TIME_IN.
    input wire rtca_time_t TIME_IN,     // Time value to load.
    input wire logic ALM_WE_IN,         // Pulse: load ALM_IN in bank one.
    input wire rtca_alarm_t ALM_IN,     // Alarm value to load.
    input wire logic ALARM_CLR_IN,      // Pulse: initialise alarm fields.
    input wire logic ROUND_REQ_IN,      // Pulse: round seconds request.
    input wire logic CNT_RST_REQ_IN,    // Pulse: second counter reset.
    output rtca_time_t TIME_OUT,        // Current time, registered.
    output rtca_alarm_t ALARM_OUT,      // Current alarm fields, registered.
    output logic ROUND_BUSY_OUT,        // Rounding still pending.
    output logic CNT_RST_BUSY_OUT,      // Counter reset still pending.
    output logic ALARM_N_OUT,           // Alarm pin, low pulse.
    output logic RTC_IRQ_N_OUT          // Interrupt request, falling edge.
);

    typedef struct packed {
        rtca_time_t tm;
        rtca_alarm_t al;
        logic round_pend;
        logic crst_pend;
        logic match_prev;
        logic pulse;
    } rtca_state_t;

    rtca_state_t s_q;
    rtca_state_t s_d;
    logic ls_tick;
    logic sec_tick;
    logic hz16_tick;
    logic match;
    logic ev;
    logic c_min;
    logic c_hour;
    logic c_day;
    rtca_src_t src;

    // ****************************************************************
    // Source selection
    // ****************************************************************
    function automatic rtca_src_t src_sel(input rtca_ctrl_t c);
        if (c.one_hz_disable && c.sixteen_hz_disable && c.alarm_enable) begin
            return SRC_ALARM;
        end else if (!c.one_hz_disable && c.sixteen_hz_disable &&
                     !c.alarm_enable) begin
            return SRC_1HZ;
        end else if (c.one_hz_disable && !c.sixteen_hz_disable &&
                     !c.alarm_enable) begin
            return SRC_16HZ;
        end else begin
            return SRC_NONE;
        end
    endfunction

    rtca_prescaler #(
        .LS_DIV(LS_DIV)
    ) u_pre (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .clr_in(s_q.crst_pend),
        .ls_tick_out(ls_tick),
        .sec_tick_out(sec_tick),
        .hz16_tick_out(hz16_tick)
    );

    assign src = src_sel(CTRL_IN);
    assign match = (s_q.al.min == s_q.tm.min) &&
        (s_q.al.hour == s_q.tm.hour) && (s_q.al.date == s_q.tm.date) &&
        (s_q.al.dow == s_q.tm.dow);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        c_min = 1'b0;
        c_hour = 1'b0;
        c_day = 1'b0;
        ev = 1'b0;
        // Time only moves when running; the prescaler never stops.
        if (sec_tick && CTRL_IN.clock_run_enable) begin
            if (s_q.round_pend) begin
                c_min = (s_q.tm.sec >= `RTCA_SEC_HALF);
                s_d.tm.sec = `RTCA_ZERO6;
            end else if (s_q.tm.sec == `RTCA_SEC_MAX) begin
                c_min = 1'b1;
                s_d.tm.sec = `RTCA_ZERO6;
            end else begin
                s_d.tm.sec = s_q.tm.sec + 6'h01;
            end
            s_d.round_pend = 1'b0;
        end
        if (c_min) begin
            c_hour = (s_q.tm.min == `RTCA_MIN_MAX);
            s_d.tm.min = c_hour ? `RTCA_ZERO6 : s_q.tm.min + 6'h01;
        end
        if (c_hour) begin
            c_day = (s_q.tm.hour == `RTCA_HOUR_MAX);
            s_d.tm.hour = c_day ? `RTCA_ZERO5 : s_q.tm.hour + 5'h01;
        end
        if (c_day) begin
            s_d.tm.date = (s_q.tm.date == `RTCA_DATE_MAX) ?
                `RTCA_DATE_FIRST : s_q.tm.date + 5'h01;
            s_d.tm.dow = (s_q.tm.dow == `RTCA_DOW_MAX) ?
                `RTCA_DOW_SUNDAY : s_q.tm.dow + 3'h1;
        end
        if (TIME_WE_IN) begin
            s_d.tm = TIME_IN;
        end
        // A new request in the completing cycle stays pending.
        if (ROUND_REQ_IN) begin
            s_d.round_pend = 1'b1;
        end
        if (ls_tick) begin
            s_d.crst_pend = 1'b0;
        end
        if (CNT_RST_REQ_IN) begin
            s_d.crst_pend = 1'b1;
        end
        if (ALARM_CLR_IN) begin
            s_d.al.min = `RTCA_ZERO6;
            s_d.al.hour = `RTCA_ZERO5;
            s_d.al.date = `RTCA_DATE_FIRST;
            s_d.al.dow = `RTCA_DOW_SUNDAY;
        end else if (ALM_WE_IN && CTRL_IN.bank_select) begin
            s_d.al = ALM_IN;
        end
        // Events are judged on the low-speed tick, so a new time or
        // alarm value can take up to one low-speed period to count.
        if (ls_tick) begin
            s_d.match_prev = match;
            case (src)
                SRC_ALARM: ev = match && !s_q.match_prev;
                SRC_1HZ: ev = sec_tick;
                SRC_16HZ: ev = hz16_tick;
                default: ev = 1'b0;
            endcase
            s_d.pulse = ev && CTRL_IN.interrupt_enable;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign TIME_OUT = s_q.tm;
    assign ALARM_OUT = s_q.al;
    assign ROUND_BUSY_OUT = s_q.round_pend;
    assign CNT_RST_BUSY_OUT = s_q.crst_pend;
    assign ALARM_N_OUT = !s_q.pulse;
    assign RTC_IRQ_N_OUT = !s_q.pulse;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    chk_pin_irq_same: assert property (
        ALARM_N_OUT == RTC_IRQ_N_OUT)
        else $error("alarm pin and irq differ");
    chk_irq_fall_tick: assert property (
        $fell(RTC_IRQ_N_OUT) |-> $past(ls_tick) &&
        $past(CTRL_IN.interrupt_enable))
        else $error("irq fell off a low-speed tick or while disabled");
    chk_sec_advance: assert property (
        sec_tick && CTRL_IN.clock_run_enable && !TIME_WE_IN &&
        !s_q.round_pend && s_q.tm.sec < `RTCA_SEC_MAX
        |=> TIME_OUT.sec == $past(TIME_OUT.sec) + 6'h01)
        else $error("seconds did not advance on tick");
    chk_halt_time: assert property (
        !CTRL_IN.clock_run_enable && !TIME_WE_IN |=> $stable(TIME_OUT))
        else $error("time moved while halted");
    chk_alarm_init: assert property (
        ALARM_CLR_IN |=> ALARM_OUT.min == `RTCA_ZERO6 &&
        ALARM_OUT.hour == `RTCA_ZERO5 &&
        ALARM_OUT.date == `RTCA_DATE_FIRST &&
        ALARM_OUT.dow == `RTCA_DOW_SUNDAY)
        else $error("alarm clear gave wrong fields");
    chk_round_low: assert property (
        sec_tick && CTRL_IN.clock_run_enable && s_q.round_pend &&
        !TIME_WE_IN && s_q.tm.sec < `RTCA_SEC_HALF
        |=> TIME_OUT.sec == `RTCA_ZERO6 && $stable(TIME_OUT.min))
        else $error("rounding below half minute went wrong");
    chk_round_busy: assert property (
        ROUND_REQ_IN |=> ROUND_BUSY_OUT)
        else $error("round request not shown busy");
    chk_crst_busy: assert property (
        CNT_RST_REQ_IN |=> CNT_RST_BUSY_OUT ##1
        (CNT_RST_BUSY_OUT || $past(ls_tick)))
        else $error("counter reset not shown busy");
    chk_one_hz_train: assert property (
        sec_tick && src == SRC_1HZ && CTRL_IN.interrupt_enable
        |=> !RTC_IRQ_N_OUT && !ALARM_N_OUT)
        else $error("1 Hz pulse missing");
    chk_hz16_train: assert property (
        hz16_tick && src == SRC_16HZ && CTRL_IN.interrupt_enable
        |=> !RTC_IRQ_N_OUT)
        else $error("16 Hz pulse missing");

endmodule

//--- verif/rtca_top_tb.sv
// Self-checking bench for the real-time clock access and alarm block.
// Assumes the package and design files are compiled before this file.
`timescale 1ns/1ps
module rtca_top_tb;
    import rtca_pkg::*;
    // A short low-speed divide keeps one full second near 65k cycles.
    localparam int LSD = 2;
    localparam int SEC = 32768 * LSD;
    localparam int P16 = 2048 * LSD;
    localparam rtca_alarm_t ACLR = {5'h01, 3'h0, 5'h00, 6'h00};
    localparam rtca_alarm_t AV = {5'h05, 3'h1, 5'h0C, 6'h00};
    localparam rtca_alarm_t AW = {5'h09, 3'h3, 5'h07, 6'h1E};
    localparam rtca_time_t TM = {5'h05, 3'h1, 5'h0C, 6'h00, 6'h0A};
    localparam rtca_time_t TR = {5'h05, 3'h1, 5'h0C, 6'h0A, 6'h2D};
    localparam rtca_time_t TRX = {5'h05, 3'h1, 5'h0C, 6'h0B, 6'h00};
    typedef struct packed {
        logic bank;
        logic we;
        logic clr;
        rtca_alarm_t din;
        rtca_alarm_t exp;
    } rtca_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    rtca_ctrl_t ctrl = '0;
    logic time_we = 1'b0;
    rtca_time_t time_d = '0;
    logic alm_we = 1'b0;
    rtca_alarm_t alm_d = '0;
    logic alm_clr = 1'b0;
    logic round_req = 1'b0;
    logic cnt_rst = 1'b0;
    rtca_time_t t_out;
    rtca_alarm_t a_out;
    logic round_busy, cnt_busy, alarm_n, irq_n;
    int bad_count = 0;
    int compares = 0;
    int n;
    int w;
    rtca_time_t tv;
    rtca_row_t rows [5] = '{{1'b1, 1'b0, 1'b1, AW, ACLR},
        {1'b1, 1'b1, 1'b0, AV, AV}, {1'b0, 1'b1, 1'b0, AW, AV},
        {1'b1, 1'b1, 1'b1, AW, ACLR}, {1'b1, 1'b1, 1'b0, AV, AV}};

    always #5 clk = ~clk;

    rtca_top #(.LS_DIV(LSD)) rtca_top_i (
        .CLK_IN(clk), .RST_N_IN(rst_n), .CTRL_IN(ctrl),
        .TIME_WE_IN(time_we), .TIME_IN(time_d), .ALM_WE_IN(alm_we),
        .ALM_IN(alm_d), .ALARM_CLR_IN(alm_clr), .ROUND_REQ_IN(round_req),
        .CNT_RST_REQ_IN(cnt_rst), .TIME_OUT(t_out), .ALARM_OUT(a_out),
        .ROUND_BUSY_OUT(round_busy), .CNT_RST_BUSY_OUT(cnt_busy),
        .ALARM_N_OUT(alarm_n), .RTC_IRQ_N_OUT(irq_n));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic end_sim();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_low(input int lim, output int cnt);
        cnt = 0;
        while (alarm_n !== 1'b0 && cnt < lim) begin
            @(negedge clk);
            cnt++;
        end
    endtask

    // The request line must follow the pin for the whole pulse.
    task automatic low_width(output int cnt);
        cnt = 0;
        while (alarm_n === 1'b0 && cnt < 4 * LSD) begin
            check(irq_n, 1'b0);
            @(negedge clk);
            cnt++;
        end
        check(irq_n, 1'b1);
    endtask

    task automatic quiet(input int len);
        int lows;
        lows = 0;
        repeat (len) begin
            @(negedge clk);
            if (alarm_n !== 1'b1 || irq_n !== 1'b1) lows++;
        end
        check(lows, 0);
    endtask

    task automatic set_ctrl(input logic [5:0] v);
        @(posedge clk);
        ctrl <= rtca_ctrl_t'(v);
        @(negedge clk);
    endtask

    task automatic load_time(input rtca_time_t v);
        @(posedge clk);
        time_d <= v;
        time_we <= 1'b1;
        @(posedge clk);
        time_we <= 1'b0;
    endtask

    // Reads the time twice in a row and repeats until both reads agree, for at most four tries.
    task automatic read_pair(output rtca_time_t v);
        rtca_time_t a;
        int k;
        k = 0;
        do begin
            @(negedge clk);
            a = t_out;
            @(negedge clk);
            v = t_out;
            k++;
        end while (a !== v && k < 4);
    endtask

    initial begin
        repeat (SEC + 6 * P16) @(posedge clk);
        bad_count++;
        end_sim();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check(t_out, 25'h0);
        check(a_out, 19'h0);
        check({round_busy, cnt_busy, alarm_n, irq_n}, 4'h3);
        foreach (rows[i]) begin
            @(posedge clk);
            ctrl.bank_select <= rows[i].bank;
            @(posedge clk);
            alm_we <= rows[i].we;
            alm_clr <= rows[i].clr;
            alm_d <= rows[i].din;
            @(posedge clk);
            alm_we <= 1'b0;
            alm_clr <= 1'b0;
            @(negedge clk);
            check(a_out, rows[i].exp);
        end
        // Sixteen per second, then the same divider with requests off.
        set_ctrl(6'b010110);
        wait_low(P16 + 10, n);
        check(n < P16 + 10, 1'b1);
        low_width(w);
        check(w, LSD);
        wait_low(P16 + 10, n);
        check(w + n, P16);
        // Let the second pulse finish before the requests are turned off.
        low_width(w);
        check(w, LSD);
        set_ctrl(6'b000110);
        quiet(P16 + 10);
        set_ctrl(6'b010011);
        quiet(P16 + 10);
        // Alarm set up in the safe order, then a match entered by a time
        // write; it must fire once only.
        set_ctrl(6'b100111);
        @(posedge clk);
        alm_clr <= 1'b1;
        @(posedge clk);
        alm_clr <= 1'b0;
        alm_d <= AV;
        alm_we <= 1'b1;
        @(posedge clk);
        alm_we <= 1'b0;
        set_ctrl(6'b101111);
        set_ctrl(6'b111111);
        check(a_out, AV);
        quiet(40);
        load_time(TM);
        @(negedge clk);
        check(t_out, TM);
        wait_low(LSD + 3, n);
        check(n < LSD + 3, 1'b1);
        low_width(w);
        check(w, LSD);
        // The handler arms the next alarm straight after the match.
        @(posedge clk);
        alm_d <= AW;
        alm_we <= 1'b1;
        @(posedge clk);
        alm_we <= 1'b0;
        @(negedge clk);
        check(a_out, AW);
        quiet(40);
        // Counter reset, then rounding with carry on the next second.
        set_ctrl(6'b100101);
        @(posedge clk);
        cnt_rst <= 1'b1;
        @(posedge clk);
        cnt_rst <= 1'b0;
        @(negedge clk);
        check(cnt_busy, 1'b1);
        n = 0;
        while (cnt_busy === 1'b1 && n < LSD + 4) begin
            @(negedge clk);
            n++;
        end
        check(cnt_busy, 1'b0);
        load_time(TR);
        round_req <= 1'b1;
        @(posedge clk);
        round_req <= 1'b0;
        @(negedge clk);
        check(round_busy, 1'b1);
        set_ctrl(6'b110101);
        wait_low(SEC + 20, n);
        check(n > SEC - 20 && n <= SEC, 1'b1);
        check(t_out, TRX);
        check(round_busy, 1'b0);
        low_width(w);
        check(w, LSD);
        read_pair(tv);
        check(tv, TRX);
        // Clock-stop method: halt after the tick, rewrite, run again.
        set_ctrl(6'b010101);
        load_time(TM);
        repeat (4) @(negedge clk);
        check(t_out, TM);
        set_ctrl(6'b110101);
        end_sim();
    end
endmodule
